// ### logic/shutdown_output_stage.sv
`timescale 1ns/1ps
// ***************************************************************
// One output: normal waveform or shutdown state, inactive level only after dead-band
// ***************************************************************
module shutdown_output_stage #(
   parameter int DB_WIDTH = 8
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic shutdown_active,
   input wire logic [1:0] level,
   input wire logic polarity,
   input wire logic waveform,
   input wire logic [DB_WIDTH-1:0] deadband,
   output logic drive_value_q,
   output logic drive_enable_q
);

   logic [DB_WIDTH-1:0] count_q;
   logic [DB_WIDTH-1:0] count_d;
   logic value_d;
   logic enable_d;

   always_comb
   begin
      count_d = count_q;
      value_d = waveform ^ polarity;
      enable_d = 1'b1;
      if (!shutdown_active)
      begin
         count_d = '0;
      end
      else
      begin
         case (level)
            shutdown_select_pkg::LEVEL_HIGH: value_d = 1'b1;
            shutdown_select_pkg::LEVEL_LOW: value_d = 1'b0;
            shutdown_select_pkg::LEVEL_TRISTATE:
            begin
               value_d = polarity;
               enable_d = 1'b0;
            end
            default:
            begin
               if (count_q >= deadband)
               begin
                  value_d = polarity;
               end
               else
               begin
                  count_d = count_q + 1'b1;
               end
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         count_q <= '0;
         drive_value_q <= 1'b0;
         drive_enable_q <= 1'b1;
      end
      else
      begin
         count_q <= count_d;
         drive_value_q <= value_d;
         drive_enable_q <= enable_d;
      end
   end

endmodule

// ### logic/shutdown_select.sv
// Implementation choices: the register offsets and register access over APB.
`timescale 1ns/1ps
module shutdown_select #(
   parameter int DB_WIDTH = shutdown_select_pkg::DEADBAND_WIDTH
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic input_pin,
   input wire logic first_pwm_output,
   input wire logic second_pwm_output,
   input wire logic third_pwm_output,
   input wire logic fourth_pwm_output,
   input wire logic first_comparator_sync_output,
   output logic selected_input,
   output logic complementary_output_a,
   output logic complementary_output_a_oe,
   output logic complementary_output_b,
   output logic complementary_output_b_oe
);

   // ***************************************************************
   // Register state
   // ***************************************************************
   shutdown_select_pkg::shutdown_sel_s sel_q;
   shutdown_select_pkg::shutdown_sel_s sel_d;
   logic shutdown_active_flag_q;
   logic shutdown_active_flag_d;
   logic output_a_polarity_q;
   logic output_a_polarity_d;
   logic output_b_polarity_q;
   logic output_b_polarity_d;
   logic [DB_WIDTH-1:0] deadband_q;
   logic [DB_WIDTH-1:0] deadband_d;
   logic [31:0] prdata_d;
   logic pslverr_d;
   logic pready_d;
   logic [1:0] pin_sync_q;
   logic pin_synced;
   logic selected_d;
   logic selected_q;
   logic wave_a;
   logic wave_b;
   shutdown_select_pkg::pin_drive_s drive_a;
   shutdown_select_pkg::pin_drive_s drive_b;

   function automatic logic hit(input logic [11:0] addr, input logic [11:0] offset);
      hit = (addr == offset);
   endfunction

   function automatic logic [7:0] sel_to_byte(input shutdown_select_pkg::shutdown_sel_s s);
      sel_to_byte = {s.output_b_shutdown_level, s.output_a_shutdown_level, 1'b0, s.input_source_select};
   endfunction

   // ***************************************************************
   // APB slave, zero wait states
   // ***************************************************************
   always_comb
   begin
      sel_d = sel_q;
      shutdown_active_flag_d = shutdown_active_flag_q;
      output_a_polarity_d = output_a_polarity_q;
      output_b_polarity_d = output_b_polarity_q;
      deadband_d = deadband_q;
      prdata_d = prdata;
      pslverr_d = 1'b0;
      pready_d = 1'b0;
      if (psel && !penable)
      begin
         pready_d = 1'b1;
         prdata_d = 32'h0000_0000;
         if (hit(paddr, shutdown_select_pkg::SHUTDOWN_SEL_OFFSET))
         begin
            if (pwrite)
            begin
               sel_d.output_b_shutdown_level = pwdata[shutdown_select_pkg::B_LEVEL_LSB +: 2];
               sel_d.output_a_shutdown_level = pwdata[shutdown_select_pkg::A_LEVEL_LSB +: 2];
               sel_d.input_source_select = pwdata[shutdown_select_pkg::SOURCE_LSB +: 3];
            end
            else
            begin
               prdata_d = {24'h00_0000, sel_to_byte(sel_q)};
            end
         end
         else if (hit(paddr, shutdown_select_pkg::CONTROL_OFFSET))
         begin
            if (pwrite)
            begin
               shutdown_active_flag_d = pwdata[shutdown_select_pkg::CTRL_SHUTDOWN_BIT];
               output_a_polarity_d = pwdata[shutdown_select_pkg::CTRL_POL_A_BIT];
               output_b_polarity_d = pwdata[shutdown_select_pkg::CTRL_POL_B_BIT];
            end
            else
            begin
               prdata_d = {29'h0000_0000, output_b_polarity_q, output_a_polarity_q, shutdown_active_flag_q};
            end
         end
         else if (hit(paddr, shutdown_select_pkg::STATUS_OFFSET))
         begin
            pslverr_d = pwrite;
            prdata_d = {28'h000_0000, complementary_output_b_oe, complementary_output_b,
                        complementary_output_a_oe, complementary_output_a};
         end
         else if (hit(paddr, shutdown_select_pkg::DEADBAND_OFFSET))
         begin
            if (pwrite)
            begin
               deadband_d = pwdata[DB_WIDTH-1:0];
            end
            else
            begin
               prdata_d = {{(32-DB_WIDTH){1'b0}}, deadband_q};
            end
         end
         else
         begin
            pslverr_d = 1'b1;
         end
      end
   end

   // ***************************************************************
   // Input source selection
   // ***************************************************************
   assign pin_synced = pin_sync_q[1];

   always_comb
   begin
      case (sel_q.input_source_select)
         shutdown_select_pkg::SRC_PIN: selected_d = pin_synced;
         shutdown_select_pkg::SRC_PWM4: selected_d = fourth_pwm_output;
         shutdown_select_pkg::SRC_PWM3: selected_d = third_pwm_output;
         shutdown_select_pkg::SRC_PWM2: selected_d = second_pwm_output;
         shutdown_select_pkg::SRC_PWM1: selected_d = first_pwm_output;
         shutdown_select_pkg::SRC_COMPARATOR: selected_d = first_comparator_sync_output;
         default: selected_d = 1'b0;
      endcase
   end

   assign wave_a = selected_q;
   assign wave_b = ~selected_q;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sel_q <= shutdown_select_pkg::SHUTDOWN_SEL_RESET[6:0];
         shutdown_active_flag_q <= shutdown_select_pkg::CONTROL_RESET[0];
         output_a_polarity_q <= shutdown_select_pkg::CONTROL_RESET[1];
         output_b_polarity_q <= shutdown_select_pkg::CONTROL_RESET[2];
         deadband_q <= shutdown_select_pkg::DEADBAND_RESET[DB_WIDTH-1:0];
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
         pin_sync_q <= 2'h0;
         selected_q <= 1'b0;
      end
      else
      begin
         sel_q <= sel_d;
         shutdown_active_flag_q <= shutdown_active_flag_d;
         output_a_polarity_q <= output_a_polarity_d;
         output_b_polarity_q <= output_b_polarity_d;
         deadband_q <= deadband_d;
         prdata <= prdata_d;
         pready <= pready_d;
         pslverr <= pslverr_d;
         pin_sync_q <= {pin_sync_q[0], input_pin};
         selected_q <= selected_d;
      end
   end

   assign selected_input = selected_q;

   // ***************************************************************
   // Output stages
   // ***************************************************************
   shutdown_output_stage #(.DB_WIDTH(DB_WIDTH)) stage_a
   (
      .pclk(pclk),
      .presetn(presetn),
      .shutdown_active(shutdown_active_flag_q),
      .level(sel_q.output_a_shutdown_level),
      .polarity(output_a_polarity_q),
      .waveform(wave_a),
      .deadband(deadband_q),
      .drive_value_q(drive_a.value),
      .drive_enable_q(drive_a.enable)
   );

   shutdown_output_stage #(.DB_WIDTH(DB_WIDTH)) stage_b
   (
      .pclk(pclk),
      .presetn(presetn),
      .shutdown_active(shutdown_active_flag_q),
      .level(sel_q.output_b_shutdown_level),
      .polarity(output_b_polarity_q),
      .waveform(wave_b),
      .deadband(deadband_q),
      .drive_value_q(drive_b.value),
      .drive_enable_q(drive_b.enable)
   );

   assign complementary_output_a = drive_a.value;
   assign complementary_output_a_oe = drive_a.enable;
   assign complementary_output_b = drive_b.value;
   assign complementary_output_b_oe = drive_b.enable;

   // ***************************************************************
   // Checks
   // ***************************************************************
   AST_B_HIGH: assert property (@(posedge pclk) disable iff (!presetn)
      shutdown_active_flag_q && sel_q.output_b_shutdown_level == 2'b11 |=> complementary_output_b)
      else $error("B not high in shutdown code 11");
   AST_B_LOW: assert property (@(posedge pclk) disable iff (!presetn)
      shutdown_active_flag_q && sel_q.output_b_shutdown_level == 2'b10 |=> !complementary_output_b)
      else $error("B not low in shutdown code 10");
   AST_B_TRI: assert property (@(posedge pclk) disable iff (!presetn)
      shutdown_active_flag_q && sel_q.output_b_shutdown_level == 2'b01 |=> !complementary_output_b_oe)
      else $error("B still enabled in code 01");
   AST_A_HIGH_LOW: assert property (@(posedge pclk) disable iff (!presetn)
      shutdown_active_flag_q && sel_q.output_a_shutdown_level[1]
      |=> complementary_output_a == $past(sel_q.output_a_shutdown_level[0]))
      else $error("A forced level wrong");
   AST_A_TRI: assert property (@(posedge pclk) disable iff (!presetn)
      shutdown_active_flag_q && sel_q.output_a_shutdown_level == 2'b01 |=> !complementary_output_a_oe)
      else $error("A still enabled in code 01");
   AST_NORMAL: assert property (@(posedge pclk) disable iff (!presetn)
      !shutdown_active_flag_q |=> complementary_output_a_oe && complementary_output_b_oe
      && complementary_output_a == ($past(wave_a) ^ $past(output_a_polarity_q))
      && complementary_output_b == ($past(wave_b) ^ $past(output_b_polarity_q)))
      else $error("Normal operation not followed");
   AST_B_INACTIVE: assert property (@(posedge pclk) disable iff (!presetn)
      shutdown_active_flag_q && sel_q.output_b_shutdown_level == 2'b00 && deadband_q == '0
      ##1 $stable(sel_q) && shutdown_active_flag_q && $stable(deadband_q)
      |=> complementary_output_b == $past(output_b_polarity_q))
      else $error("B not inactive after dead-band");
   AST_SRC_PWM4: assert property (@(posedge pclk) disable iff (!presetn)
      sel_q.input_source_select == 3'b101 |=> selected_input == $past(fourth_pwm_output))
      else $error("Source 101 not fourth PWM");
   AST_SRC_CMP: assert property (@(posedge pclk) disable iff (!presetn)
      sel_q.input_source_select == 3'b000 |=> selected_input == $past(first_comparator_sync_output))
      else $error("Source 000 not comparator");
   AST_BIT3: assert property (@(posedge pclk) disable iff (!presetn)
      psel && !penable && !pwrite && paddr == 12'h000 |=> prdata[3] == 1'b0)
      else $error("Bit 3 read nonzero");

endmodule

// ### logic/shutdown_select_pkg.sv
package shutdown_select_pkg;

   // ***************************************************************
   // Register map
   // ***************************************************************
   localparam logic [11:0] SHUTDOWN_SEL_OFFSET = 12'h000;
   localparam logic [11:0] CONTROL_OFFSET = 12'h004;
   localparam logic [11:0] STATUS_OFFSET = 12'h008;
   localparam logic [11:0] DEADBAND_OFFSET = 12'h00c;

   // ***************************************************************
   // Field positions and reset values
   // ***************************************************************
   localparam int B_LEVEL_LSB = 6;
   localparam int A_LEVEL_LSB = 4;
   localparam int SOURCE_LSB = 0;
   localparam int CTRL_SHUTDOWN_BIT = 0;
   localparam int CTRL_POL_A_BIT = 1;
   localparam int CTRL_POL_B_BIT = 2;
   localparam logic [7:0] SHUTDOWN_SEL_RESET = 8'h00;
   localparam logic [2:0] CONTROL_RESET = 3'h0;
   localparam logic [7:0] DEADBAND_RESET = 8'h00;
   localparam int DEADBAND_WIDTH = 8;

   // ***************************************************************
   // Types
   // ***************************************************************
   typedef enum logic [1:0]
   {
      LEVEL_INACTIVE = 2'b00,
      LEVEL_TRISTATE = 2'b01,
      LEVEL_LOW = 2'b10,
      LEVEL_HIGH = 2'b11
   } shutdown_level_e;

   typedef enum logic [2:0]
   {
      SRC_COMPARATOR = 3'b000,
      SRC_UNUSED = 3'b001,
      SRC_PWM1 = 3'b010,
      SRC_PWM2 = 3'b011,
      SRC_PWM3 = 3'b100,
      SRC_PWM4 = 3'b101,
      SRC_PIN = 3'b110,
      SRC_RESERVED = 3'b111
   } input_source_e;

   typedef struct packed
   {
      logic [1:0] output_b_shutdown_level;
      logic [1:0] output_a_shutdown_level;
      logic [2:0] input_source_select;
   } shutdown_sel_s;

   typedef struct packed
   {
      logic value;
      logic enable;
   } pin_drive_s;

endpackage

// ### tb/power_stage_model.sv
`timescale 1ns/1ps
// ***************************************************************
// Power stage seen from the two output pins
// ***************************************************************
module power_stage_model
(
   input wire logic pclk,
   input wire logic drive_a,
   input wire logic oe_a,
   input wire logic drive_b,
   input wire logic oe_b,
   output logic pad_a,
   output logic pad_b
);
   logic last_a;
   logic last_b;

   always @(posedge pclk)
   begin
      last_a <= pad_a;
      last_b <= pad_b;
   end

   // Released pin has no pull: it toggles so a stale level never passes
   assign pad_a = oe_a ? drive_a : ~last_a;
   assign pad_b = oe_b ? drive_b : ~last_b;
endmodule

// ### tb/test_shutdown_select.sv
`timescale 1ns/1ps
module test_shutdown_select;
   logic pclk = 1'b0;
   logic presetn;
   logic psel;
   logic penable;
   logic pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [7:0] src_v;
   logic sel_o;
   logic out_a;
   logic oe_a;
   logic out_b;
   logic oe_b;
   logic pad_a;
   logic pad_b;
   logic [31:0] rd;
   logic er;
   logic s;
   int n_errors = 0;
   int n_tests = 0;
   int seed = 2;
   int c;
   int t;
   int i;
   int p;

   always #4 pclk = ~pclk;

   shutdown_select DUT
   (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .input_pin(src_v[6]), .first_pwm_output(src_v[2]), .second_pwm_output(src_v[3]),
      .third_pwm_output(src_v[4]), .fourth_pwm_output(src_v[5]),
      .first_comparator_sync_output(src_v[0]), .selected_input(sel_o),
      .complementary_output_a(out_a), .complementary_output_a_oe(oe_a),
      .complementary_output_b(out_b), .complementary_output_b_oe(oe_b)
   );

   power_stage_model stage
   (
      .pclk(pclk), .drive_a(out_a), .oe_a(oe_a), .drive_b(out_b), .oe_b(oe_b),
      .pad_a(pad_a), .pad_b(pad_b)
   );

   // ***************************************************************
   // Checking and bus tasks
   // ***************************************************************
   task stop_test;
   begin
      $display("errors %0d tests %0d", n_errors, n_tests);
      if (n_errors == 0 && n_tests > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   end
   endtask

   task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
   begin
      n_tests++;
      if (got !== exp)
      begin
         n_errors++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   end
   endtask

   // Entered just after a rising edge; leaves one idle cycle behind
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
   begin
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      // Read right after an edge, so the values are those sampled at it
      do
      begin
         @(posedge pclk);
         k++;
      end
      while (pready !== 1'b1 && k < 20);
      if (pready !== 1'b1)
      begin
         n_errors++;
         stop_test();
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   end
   endtask

   function automatic logic [1:0] exp_pin(input int lvl, input logic pol, input logic nrm,
                                         input logic sd, input logic dbd);
   begin
      if (!sd)
         return {1'b1, nrm};
      case (lvl)
         3: return 2'b11;
         2: return 2'b10;
         1: return {1'b0, pol};
         default: return {1'b1, dbd ? pol : nrm};
      endcase
   end
   endfunction

   task pins(input int la, input int lb, input logic pa, input logic pb, input logic sd, input logic dbd);
      logic [1:0] ea;
      logic [1:0] eb;
   begin
      ea = exp_pin(la, pa, s ^ pa, sd, dbd);
      eb = exp_pin(lb, pb, ~s ^ pb, sd, dbd);
      chk("pin a", {30'h0, ea}, {30'h0, oe_a, out_a});
      chk("pin b", {30'h0, eb}, {30'h0, oe_b, out_b});
      if (ea[1])
         chk("pad a", {31'h0, ea[0]}, {31'h0, pad_a});
      if (eb[1])
         chk("pad b", {31'h0, eb[0]}, {31'h0, pad_b});
      apb(1'b0, shutdown_select_pkg::STATUS_OFFSET, 32'h0);
      chk("status", {28'h0, eb, ea}, rd);
   end
   endtask

   // ***************************************************************
   // Main sequence
   // ***************************************************************
   initial
   begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      src_v = 8'h00;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      for (i = 0; i < 4; i++)
      begin
         if (i != 2)
         begin
            apb(1'b0, 12'(i * 4), 32'h0);
            chk("reset value", 32'h0, rd);
         end
      end
      apb(1'b1, shutdown_select_pkg::SHUTDOWN_SEL_OFFSET, 32'hff);
      apb(1'b0, shutdown_select_pkg::SHUTDOWN_SEL_OFFSET, 32'h0);
      chk("select", 32'hf7, rd);
      apb(1'b1, shutdown_select_pkg::STATUS_OFFSET, 32'hf);
      chk("slverr", 32'h1, {31'h0, er});
      apb(1'b0, 12'h010, 32'h0);
      chk("slverr", 32'h1, {31'h0, er});
      chk("rdata", 32'h0, rd);
      // Every source code with random inputs and every polarity pair
      for (c = 0; c < 8; c++)
      begin
         for (t = 0; t < 4; t++)
         begin
            src_v <= 8'($random(seed));
            apb(1'b1, shutdown_select_pkg::CONTROL_OFFSET, 32'(t << 1));
            apb(1'b1, shutdown_select_pkg::SHUTDOWN_SEL_OFFSET, 32'(c));
            repeat (6) @(posedge pclk);
            s = (c == 1 || c == 7) ? 1'b0 : src_v[c];
            chk("selected", {31'h0, s}, {31'h0, sel_o});
            pins(0, 0, t[0], t[1], 1'b0, 1'b0);
         end
      end
      // Every pair of shutdown codes under every polarity
      apb(1'b1, shutdown_select_pkg::DEADBAND_OFFSET, 32'h0);
      for (i = 0; i < 16; i++)
      begin
         for (p = 0; p < 4; p++)
         begin
            src_v <= 8'($random(seed));
            apb(1'b1, shutdown_select_pkg::SHUTDOWN_SEL_OFFSET, 32'((i << 4) | 2));
            apb(1'b1, shutdown_select_pkg::CONTROL_OFFSET, 32'((p << 1) | 1));
            repeat (8) @(posedge pclk);
            s = src_v[2];
            pins(i % 4, i / 4, p[0], p[1], 1'b1, 1'b1);
            apb(1'b1, shutdown_select_pkg::CONTROL_OFFSET, 32'(p << 1));
         end
      end
      // Inactive level only after the dead-band has run out
      apb(1'b1, shutdown_select_pkg::DEADBAND_OFFSET, 32'd20);
      apb(1'b1, shutdown_select_pkg::SHUTDOWN_SEL_OFFSET, 32'h2);
      for (t = 0; t < 2; t++)
      begin
         src_v <= 8'(t << 2);
         apb(1'b1, shutdown_select_pkg::CONTROL_OFFSET, 32'h0);
         repeat (6) @(posedge pclk);
         s = t[0];
         apb(1'b1, shutdown_select_pkg::CONTROL_OFFSET, 32'h1);
         repeat (2) @(posedge pclk);
         pins(0, 0, 1'b0, 1'b0, 1'b1, 1'b0);
         // Twenty shutdown cycles of normal waveform, then the inactive level
         repeat (14) @(posedge pclk);
         chk("a before dead-band end", {31'h0, s}, {31'h0, out_a});
         chk("b before dead-band end", {31'h0, ~s}, {31'h0, out_b});
         @(posedge pclk);
         chk("a at dead-band end", 32'h0, {31'h0, out_a});
         chk("b at dead-band end", 32'h0, {31'h0, out_b});
         pins(0, 0, 1'b0, 1'b0, 1'b1, 1'b1);
      end
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, shutdown_select_pkg::SHUTDOWN_SEL_OFFSET, 32'h0);
      chk("select after reset", 32'h0, rd);
      stop_test();
   end
endmodule
